// file: wbf_fault_ctrl.sv
`timescale 1ns/10ps
module wbf_fault_ctrl #(
    parameter int unsigned SINK_FILTER = wbf_pkg::SINK_FILTER_CYC,
    parameter int unsigned RESET_TIMEOUT = wbf_pkg::RESET_TIMEOUT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic power_up_i,
    input wire logic hs_overload_i,
    input wire logic ls_overload_i,
    input wire logic hs_short_i,
    input wire logic ls_short_i,
    input wire logic ls_sink_i,
    input wire logic wide_uv_ok_i,
    input wire logic lowv_uv_ok_i,
    input wire logic all_below_uv_i,
    input wire logic feedback_sense_pin_low_i,
    input wire logic short_circuit_off_select_i,
    input wire logic sink_off_select_i,
    input wire logic undervoltage_reset_select_i,
    input wire logic clear_flags_i,
    output logic wide_input_step_down_en_o,
    output logic low_voltage_step_down_en_o,
    output logic boost_en_o,
    output logic hs_force_off_o,
    output logic ls_force_on_o,
    output logic discharge_en_o,
    output logic overload_flag_o,
    output logic short_circuit_flag_o,
    output logic low_side_sink_flag_o,
    output logic ovp_flag_o,
    output logic interrupt_out_n_o,
    output logic [wbf_pkg::ERR_CNT_W-1:0] error_count_o,
    output logic [4:0] state_o
);
    typedef struct packed {
        wbf_pkg::wbf_state_t st;
        wbf_pkg::wbf_seq_t seq;
        logic sc_latch;
        logic sink_latch;
        logic sink_mask;
        logic [wbf_pkg::SINK_CNT_W-1:0] sink_cnt;
        logic [wbf_pkg::RST_CNT_W-1:0] rst_cnt;
        logic [wbf_pkg::ERR_CNT_W-1:0] err_cnt;
        logic ovl;
        logic scf;
        logic snk;
        logic ovp;
        logic irq_n;
        logic discharge;
    } wbf_regs_t;

    wbf_regs_t r_q;
    wbf_regs_t r_d;
    logic sc_hit;
    logic sink_live;
    logic sink_trip;
    logic err_full;

    assign sc_hit = hs_short_i | ls_short_i;
    assign sink_live = ls_sink_i & ~r_q.sink_mask;
    assign sink_trip = sink_live && (r_q.sink_cnt >= wbf_pkg::SINK_CNT_W'(SINK_FILTER));
    assign err_full = (r_q.err_cnt >= wbf_pkg::ERR_CNT_LIMIT);

    always_comb begin
        r_d = r_q;
        r_d.sink_cnt = sink_live ? r_q.sink_cnt + 1'h1 : '0;
        // software clear loses against a same-cycle event
        if (clear_flags_i) begin
            r_d.ovl = 1'h0;
            r_d.scf = 1'h0;
            r_d.snk = 1'h0;
            r_d.ovp = 1'h0;
            r_d.irq_n = 1'h1;
        end
        if (hs_overload_i | ls_overload_i) r_d.ovl = 1'h1;
        if (sink_live) r_d.snk = 1'h1;
        if (wide_uv_ok_i) r_d.sink_mask = 1'h0;
        unique case (r_q.st)
            wbf_pkg::WBF_ACTIVE, wbf_pkg::WBF_RESET: begin
                if (r_q.st == wbf_pkg::WBF_RESET) begin
                    r_d.rst_cnt = r_q.rst_cnt + 1'h1;
                    if (wide_uv_ok_i && r_q.seq == wbf_pkg::WBF_SEQ_WIDE)
                        r_d.seq = wbf_pkg::WBF_SEQ_LOWV;
                    else if (lowv_uv_ok_i && r_q.seq == wbf_pkg::WBF_SEQ_LOWV)
                        r_d.seq = wbf_pkg::WBF_SEQ_BOOST;
                    else if (r_q.seq == wbf_pkg::WBF_SEQ_BOOST)
                        r_d.seq = wbf_pkg::WBF_SEQ_DONE;
                    if (r_q.seq == wbf_pkg::WBF_SEQ_DONE)
                        r_d.st = wbf_pkg::WBF_ACTIVE;
                    else if (r_q.rst_cnt >= wbf_pkg::RST_CNT_W'(RESET_TIMEOUT))
                        r_d.st = wbf_pkg::WBF_OFF;
                end
                // protections stay live in RESET too
                if (sc_hit) begin
                    r_d.st = wbf_pkg::WBF_SC_DRAIN;
                end else if (sink_trip) begin
                    r_d.snk = 1'h1;
                    if (sink_off_select_i) begin
                        r_d.st = wbf_pkg::WBF_OFF;
                        r_d.sink_latch = 1'h1;
                    end else begin
                        r_d.st = wbf_pkg::WBF_SAFE;
                        r_d.discharge = 1'h0;
                        r_d.irq_n = 1'h0;
                        r_d.err_cnt = r_q.err_cnt + 1'h1;
                    end
                end else if (feedback_sense_pin_low_i) begin
                    r_d.ovp = 1'h1;
                    r_d.st = wbf_pkg::WBF_SAFE;
                    r_d.irq_n = 1'h0;
                    r_d.err_cnt = r_q.err_cnt + 1'h1;
                end
            end
            wbf_pkg::WBF_SC_DRAIN: begin
                // low side conducts until current falls under overload limit
                if (!(hs_overload_i | ls_overload_i)) begin
                    r_d.scf = 1'h1;
                    if (short_circuit_off_select_i) begin
                        r_d.st = wbf_pkg::WBF_OFF;
                        r_d.discharge = 1'h1;
                        r_d.sc_latch = 1'h1;
                    end else begin
                        r_d.st = wbf_pkg::WBF_SAFE;
                        r_d.discharge = 1'h0;
                        r_d.irq_n = 1'h0;
                        r_d.err_cnt = r_q.err_cnt + 1'h1;
                    end
                end
            end
            wbf_pkg::WBF_SAFE: begin
                if (err_full) begin
                    r_d.st = wbf_pkg::WBF_OFF;
                end else if (all_below_uv_i && undervoltage_reset_select_i) begin
                    r_d.st = wbf_pkg::WBF_RESET;
                    r_d.seq = wbf_pkg::WBF_SEQ_WIDE;
                    r_d.rst_cnt = '0;
                    r_d.sink_mask = 1'h1;
                end
            end
            wbf_pkg::WBF_OFF: begin
                r_d.discharge = 1'h1;
                if (power_up_i) begin
                    // latched causes surface at power-up from OFF
                    r_d.scf = r_q.scf | r_q.sc_latch;
                    r_d.snk = r_q.snk | r_q.sink_latch;
                    r_d.sc_latch = 1'h0;
                    r_d.sink_latch = 1'h0;
                    r_d.err_cnt = '0;
                    r_d.discharge = 1'h0;
                    r_d.st = wbf_pkg::WBF_RESET;
                    r_d.seq = wbf_pkg::WBF_SEQ_WIDE;
                    r_d.rst_cnt = '0;
                    r_d.sink_mask = 1'h1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            r_q <= '0;
            r_q.st <= wbf_pkg::WBF_OFF;
            r_q.seq <= wbf_pkg::WBF_SEQ_WIDE;
            r_q.irq_n <= 1'h1;
            r_q.discharge <= 1'h1;
            r_q.sink_mask <= 1'h1;
        end else begin
            r_q <= r_d;
        end
    end

    logic run;
    assign run = (r_q.st == wbf_pkg::WBF_ACTIVE) || (r_q.st == wbf_pkg::WBF_RESET);
    assign wide_input_step_down_en_o = run;
    assign low_voltage_step_down_en_o = (r_q.st == wbf_pkg::WBF_ACTIVE) ||
        (run && r_q.seq != wbf_pkg::WBF_SEQ_WIDE);
    assign boost_en_o = (r_q.st == wbf_pkg::WBF_ACTIVE) ||
        (run && (r_q.seq == wbf_pkg::WBF_SEQ_BOOST || r_q.seq == wbf_pkg::WBF_SEQ_DONE));
    assign hs_force_off_o = (r_q.st == wbf_pkg::WBF_SC_DRAIN);
    assign ls_force_on_o = (r_q.st == wbf_pkg::WBF_SC_DRAIN);
    assign discharge_en_o = r_q.discharge;
    assign overload_flag_o = r_q.ovl;
    assign short_circuit_flag_o = r_q.scf;
    assign low_side_sink_flag_o = r_q.snk;
    assign ovp_flag_o = r_q.ovp;
    assign interrupt_out_n_o = r_q.irq_n;
    assign error_count_o = r_q.err_cnt;
    assign state_o = r_q.st;

    property p_overload;
        @(posedge sys_clk_i) disable iff (reset_i)
        (hs_overload_i | ls_overload_i) |=> overload_flag_o;
    endproperty
    a_overload: assert property (p_overload) else $error("overload flag not set");
    property p_sc_drain;
        @(posedge sys_clk_i) disable iff (reset_i)
        (run && sc_hit) |=> (hs_force_off_o && ls_force_on_o);
    endproperty
    a_sc_drain: assert property (p_sc_drain) else $error("short circuit drain missing");
    property p_sc_off;
        @(posedge sys_clk_i) disable iff (reset_i)
        (hs_force_off_o && !(hs_overload_i | ls_overload_i) && short_circuit_off_select_i
         && !clear_flags_i)
        |=> (state_o == wbf_pkg::WBF_OFF && discharge_en_o && short_circuit_flag_o);
    endproperty
    a_sc_off: assert property (p_sc_off) else $error("short circuit off path wrong");
    property p_sc_safe;
        @(posedge sys_clk_i) disable iff (reset_i)
        (hs_force_off_o && !(hs_overload_i | ls_overload_i) && !short_circuit_off_select_i)
        |=> (state_o == wbf_pkg::WBF_SAFE && !discharge_en_o && !interrupt_out_n_o
             && error_count_o == $past(error_count_o) + 1'h1);
    endproperty
    a_sc_safe: assert property (p_sc_safe) else $error("short circuit safe path wrong");
    property p_safe_reset;
        @(posedge sys_clk_i) disable iff (reset_i)
        (state_o == wbf_pkg::WBF_SAFE && !err_full && all_below_uv_i
         && undervoltage_reset_select_i) |=> (state_o == wbf_pkg::WBF_RESET);
    endproperty
    a_safe_reset: assert property (p_safe_reset) else $error("no reset from safe");
    property p_seq;
        @(posedge sys_clk_i) disable iff (reset_i)
        (state_o == wbf_pkg::WBF_RESET && !wide_uv_ok_i && r_q.seq == wbf_pkg::WBF_SEQ_WIDE)
        |-> (wide_input_step_down_en_o && !low_voltage_step_down_en_o && !boost_en_o);
    endproperty
    a_seq: assert property (p_seq) else $error("enable order broken");
    property p_mask;
        @(posedge sys_clk_i) disable iff (reset_i)
        (r_q.sink_mask && ls_sink_i && !low_side_sink_flag_o)
        |=> (!low_side_sink_flag_o || $past(power_up_i));
    endproperty
    a_mask: assert property (p_mask) else $error("masked sink event flagged");
    property p_sink_off;
        @(posedge sys_clk_i) disable iff (reset_i)
        (run && sink_trip && !sc_hit && sink_off_select_i) |=> !wide_input_step_down_en_o;
    endproperty
    a_sink_off: assert property (p_sink_off) else $error("sink trip kept regulator on");
    property p_sink_latch;
        @(posedge sys_clk_i) disable iff (reset_i)
        (run && sink_trip && !sc_hit && sink_off_select_i)
        |=> (state_o == wbf_pkg::WBF_OFF && r_q.sink_latch);
    endproperty
    a_sink_latch: assert property (p_sink_latch) else $error("sink off not latched");
    // repeated restarts stop once the error count reaches its limit
    property p_err_limit;
        @(posedge sys_clk_i) disable iff (reset_i)
        (state_o == wbf_pkg::WBF_SAFE && err_full) |=> (state_o == wbf_pkg::WBF_OFF);
    endproperty
    a_err_limit: assert property (p_err_limit) else $error("error limit ignored");
endmodule : wbf_fault_ctrl

// file: wbf_fault_ctrl_tb.sv
`timescale 1ns/10ps
module wbf_fault_ctrl_tb;
    localparam int unsigned SF = 8;
    localparam int unsigned RT = 50;
    logic sys_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic pu, hov, lov, hsc, lsc, snk, wok, lok, blw, fbl, sco, sno, uvr, clr;
    logic we, le, be, hso, lso, dis, ovf, scf, skf, opf, irq;
    logic [3:0] cnt;
    logic [4:0] st;
    logic [3:0] ec = 4'h0;
    logic req = 1'h0;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    wbf_fault_ctrl #(.SINK_FILTER(SF), .RESET_TIMEOUT(RT)) dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .power_up_i(pu), .hs_overload_i(hov),
        .ls_overload_i(lov), .hs_short_i(hsc), .ls_short_i(lsc), .ls_sink_i(snk),
        .wide_uv_ok_i(wok), .lowv_uv_ok_i(lok), .all_below_uv_i(blw),
        .feedback_sense_pin_low_i(fbl), .short_circuit_off_select_i(sco),
        .sink_off_select_i(sno), .undervoltage_reset_select_i(uvr), .clear_flags_i(clr),
        .wide_input_step_down_en_o(we), .low_voltage_step_down_en_o(le), .boost_en_o(be),
        .hs_force_off_o(hso), .ls_force_on_o(lso), .discharge_en_o(dis),
        .overload_flag_o(ovf), .short_circuit_flag_o(scf), .low_side_sink_flag_o(skf),
        .ovp_flag_o(opf), .interrupt_out_n_o(irq), .error_count_o(cnt), .state_o(st));
    wbf_mcu_model #(.DLY(8)) mcu (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .irq_n_i(irq), .sw_clear_i(req), .clear_o(clr));
    task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", w, e, s);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    task automatic wait_st(input logic [4:0] e, input int lim);
        #1;
        for (int i = 0; i < lim && st !== e; i++) begin
            tick(1);
            #1;
        end
        check("state", st, e);
    endtask : wait_st
    task automatic in_safe();
        ec = ec + 4'h1;
        check("irq", irq, 1'h0);
        check("count", cnt, ec);
        check("enables", {we, le, be, dis}, 4'h0);
    endtask : in_safe
    task automatic recover();
        wait_st(wbf_pkg::WBF_RESET, 4);
        check("wide only", {we, le, be}, 3'h4);
        tick(1);
        {blw, wok} <= 2'h1;
        tick(3);
        #1;
        check("lowv next", {we, le, be}, 3'h6);
        tick(1);
        lok <= 1'h1;
        wait_st(wbf_pkg::WBF_ACTIVE, 4);
        check("all on", {we, le, be}, 3'h7);
    endtask : recover
    task automatic back();
        #1;
        for (int i = 0; i < 30 && irq !== 1'h1; i++) begin
            tick(1);
            #1;
        end
        check("flags", {ovf, scf, skf, opf}, 4'h0);
        tick(1);
        {blw, wok, lok} <= 3'h4;
        recover();
    endtask : back
    task automatic t_power();
        tick(1);
        pu <= 1'h1;
        wait_st(wbf_pkg::WBF_RESET, 4);
        tick(1);
        pu <= 1'h0;
        snk <= 1'h1;
        tick(SF + 3);
        snk <= 1'h0;
        #1;
        check("masked", skf, 1'h0);
        recover();
        $display("end power-up");
    endtask : t_power
    task automatic t_ovl();
        tick(1);
        hov <= 1'h1;
        tick(1);
        hov <= 1'h0;
        tick(3);
        #1;
        check("overload", {ovf, st, we}, {1'h1, wbf_pkg::WBF_ACTIVE, 1'h1});
        $display("end overload");
    endtask : t_ovl
    task automatic t_sc_safe();
        tick(1);
        {hsc, hov} <= 2'h3;
        wait_st(wbf_pkg::WBF_SC_DRAIN, 3);
        tick(1);
        hsc <= 1'h0;
        tick(1);
        hov <= 1'h0;
        #1;
        check("drain", {st, hso, lso}, {wbf_pkg::WBF_SC_DRAIN, 2'h3});
        wait_st(wbf_pkg::WBF_SAFE, 3);
        check("sc flag", scf, 1'h1);
        in_safe();
        back();
        $display("end short to safe");
    endtask : t_sc_safe
    task automatic t_sink();
        tick(1);
        snk <= 1'h1;
        tick(SF - 1);
        #1;
        check("sink", {skf, st}, {1'h1, wbf_pkg::WBF_ACTIVE});
        wait_st(wbf_pkg::WBF_SAFE, 6);
        in_safe();
        tick(1);
        snk <= 1'h0;
        back();
        $display("end sink");
    endtask : t_sink
    task automatic t_ovp();
        tick(1);
        fbl <= 1'h1;
        wait_st(wbf_pkg::WBF_SAFE, 4);
        check("ovp flag", opf, 1'h1);
        in_safe();
        tick(1);
        fbl <= 1'h0;
        back();
        $display("end feedback short");
    endtask : t_ovp
    task automatic t_sc_off();
        tick(1);
        sco <= 1'h1;
        {lsc, lov} <= 2'h3;
        tick(2);
        {lsc, lov} <= 2'h0;
        wait_st(wbf_pkg::WBF_OFF, 4);
        check("off outputs", {we, le, be, dis}, 4'h1);
        wipe();
        tick(1);
        {wok, lok, pu} <= 3'h1;
        wait_st(wbf_pkg::WBF_RESET, 4);
        check("reported", {scf, cnt}, 5'h10);
        tick(1);
        pu <= 1'h0;
        tick(RT - 8);
        #1;
        check("still reset", st, wbf_pkg::WBF_RESET);
        wait_st(wbf_pkg::WBF_OFF, 12);
        $display("end short to off");
    endtask : t_sc_off
    task automatic wipe();
        tick(1);
        req <= 1'h1;
        tick(1);
        req <= 1'h0;
        tick(2);
        #1;
        check("cleared", {ovf, scf, skf, opf}, 4'h0);
    endtask : wipe
    task automatic t_sink_off();
        tick(1);
        {sno, wok, lok, pu} <= 4'hF;
        wait_st(wbf_pkg::WBF_RESET, 4);
        tick(1);
        pu <= 1'h0;
        wait_st(wbf_pkg::WBF_ACTIVE, 6);
        tick(1);
        snk <= 1'h1;
        wait_st(wbf_pkg::WBF_OFF, SF + 4);
        check("sink off", {skf, we, le, be}, 4'h8);
        tick(1);
        snk <= 1'h0;
        wipe();
        tick(1);
        pu <= 1'h1;
        wait_st(wbf_pkg::WBF_RESET, 4);
        check("reported", {scf, skf}, 2'h1);
        tick(1);
        pu <= 1'h0;
        $display("end sink to off");
    endtask : t_sink_off
    task automatic t_limit();
        tick(1);
        {blw, fbl} <= 2'h3;
        wait_st(wbf_pkg::WBF_OFF, 30);
        check("limit", cnt, wbf_pkg::ERR_CNT_LIMIT);
        tick(1);
        {blw, fbl} <= 2'h0;
        $display("end error limit");
    endtask : t_limit
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // a hung wait must still reach the verdict
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        {pu, hov, lov, hsc, lsc, snk, wok, lok, blw, fbl, sco, sno} = 12'h000;
        uvr = 1'h1;
        tick(3);
        reset_i <= 1'h0;
        t_power();
        t_ovl();
        t_sc_safe();
        t_sink();
        t_ovp();
        t_sc_off();
        t_sink_off();
        t_limit();
        close_out();
    end
endmodule : wbf_fault_ctrl_tb

// file: wbf_mcu_model.sv
`timescale 1ns/10ps
module wbf_mcu_model #(
    parameter int unsigned DLY = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic irq_n_i,
    input wire logic sw_clear_i,
    output logic clear_o = 1'h0
);
    int unsigned n_q = 0;
    // reads status some cycles after the interrupt, so the bench can see flags first
    always @(posedge sys_clk_i) begin
        n_q <= (reset_i || irq_n_i) ? 0 : n_q + 1;
        // the bench may also ask for a clear, e.g. while the device is off
        clear_o <= (!reset_i && !irq_n_i && n_q == DLY) || sw_clear_i;
    end
endmodule : wbf_mcu_model

// file: wbf_pkg.sv
package wbf_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SINK_FILTER_US = 20;
    localparam int unsigned SINK_FILTER_CYC = (SINK_FILTER_US * (CLK_HZ / 1_000_000));
    localparam int unsigned RESET_TIMEOUT_CYC = 50000;
    localparam int unsigned ERR_CNT_W = 4;
    localparam logic [ERR_CNT_W-1:0] ERR_CNT_LIMIT = 4'h8;
    localparam int unsigned SINK_CNT_W = 16;
    localparam int unsigned RST_CNT_W = 20;

    typedef enum logic [4:0] {
        WBF_ACTIVE = 5'h01,
        WBF_SC_DRAIN = 5'h02,
        WBF_SAFE = 5'h04,
        WBF_RESET = 5'h08,
        WBF_OFF = 5'h10
    } wbf_state_t;

    typedef enum logic [1:0] {
        WBF_SEQ_WIDE = 2'h0,
        WBF_SEQ_LOWV = 2'h1,
        WBF_SEQ_BOOST = 2'h2,
        WBF_SEQ_DONE = 2'h3
    } wbf_seq_t;
endpackage : wbf_pkg
